// file: rtl/alc_consts.svh
// Offsets, field positions, reset values and protocol codes for the AUX link config listener.
`ifndef ALC_CONSTS_SVH
`define ALC_CONSTS_SVH

// ***************************************************************
// Register-port offsets and reset values
// ***************************************************************
`define ALC_OFS_LINK_RATE 8'h02
`define ALC_OFS_LANE_CNT 8'h03
`define ALC_RST_LINK_RATE 8'h14
`define ALC_RST_LANE_CNT 8'h04
`define ALC_RST_RATE_MBPS 17'h01518

// ***************************************************************
// AUX link addresses of the tracked settings
// ***************************************************************
`define ALC_AUX_ADDR_LINK_RATE 20'h00100
`define ALC_AUX_ADDR_LANE_CNT 20'h00101

// ***************************************************************
// AUX command and reply codes
// ***************************************************************
`define ALC_CMD_NATIVE_WR 4'h8
`define ALC_CMD_NATIVE_RD 4'h9
`define ALC_REPLY_ACK 8'h00
`define ALC_REPLY_NACK 8'h10

// ***************************************************************
// Link rate codes and scale
// ***************************************************************
`define ALC_RATE_1G62 8'h06
`define ALC_RATE_2G70 8'h0A
`define ALC_RATE_5G40 8'h14
`define ALC_RATE_STEP_MBPS 17'h0010E

// ***************************************************************
// Lane count register fields
// ***************************************************************
`define ALC_LANE_CNT_MSB 4
`define ALC_LANE_CNT_LSB 0
`define ALC_LANE_WR_MASK 8'h9F
`define ALC_LANE_EF_BIT 7
`define ALC_LANES_ONE 5'h01
`define ALC_LANES_TWO 5'h02
`define ALC_LANES_FOUR 5'h04

// ***************************************************************
// Request header layout
// ***************************************************************
`define ALC_HDR_BYTES 8'h04

`endif

// file: rtl/alc_listener.sv
// AUX link config listener: snoops native AUX traffic and mirrors link rate and lane count.
// ***************************************************************
// ***************************************************************
`timescale 1ns/100ps
`include "alc_consts.svh"

module alc_listener (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input alc_pkg::alc_aux_byte_t aux_byte_i,
  input wire logic [7:0] smb_addr_i,
  input wire logic smb_wr_i,
  input wire logic [7:0] smb_wdata_i,
  output logic [7:0] smb_rdata_o,
  output logic [7:0] link_rate_o,
  output logic [7:0] lane_count_o,
  output alc_pkg::alc_rate_t rate_code_o,
  output logic [16:0] rate_mbps_o,
  output logic [3:0] lane_enable_o,
  output logic enhanced_framing_o,
  output logic ack_seen_o,
  output logic nack_seen_o
);

  // ***************************************************************
  // Frame parser state
  // ***************************************************************
  alc_pkg::alc_state_t st_r, st_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [7:0] pend_rate_r, pend_rate_nxt;
  logic [7:0] pend_lane_r, pend_lane_nxt;
  logic [8:0] pend_rate_k_r, pend_rate_k_nxt;
  logic [8:0] pend_lane_k_r, pend_lane_k_nxt;
  logic ack_r, ack_nxt;
  logic nack_r, nack_nxt;

  // ***************************************************************
  // Mirror registers
  // ***************************************************************
  logic [7:0] rate_r, rate_nxt;
  logic [7:0] lane_r, lane_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  alc_pkg::alc_rate_t code_r, code_nxt;
  logic [16:0] mbps_r, mbps_nxt;
  logic [3:0] lane_en_r, lane_en_nxt;

  logic [19:0] cur_addr;
  logic [7:0] dbyte;
  logic [8:0] dk;

  // Data byte index k within the payload, and its AUX address.
  always_comb begin
    dbyte = idx_r - `ALC_HDR_BYTES;
    dk = {1'b0, dbyte};
    cur_addr = addr_r + {12'h000, dbyte};
  end

  // ***************************************************************
  // Parser next state
  // ***************************************************************
  // A pending index of 9'h100 marks "no byte pending"; write data only
  // lands in a mirror once the sink has actually accepted it.
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    pend_rate_nxt = pend_rate_r;
    pend_lane_nxt = pend_lane_r;
    pend_rate_k_nxt = pend_rate_k_r;
    pend_lane_k_nxt = pend_lane_k_r;
    ack_nxt = 1'b0;
    nack_nxt = 1'b0;
    rate_nxt = rate_r;
    lane_nxt = lane_r;
    // SMBus writes apply first so a same-cycle AUX capture overrides them.
    if (smb_wr_i && smb_addr_i == `ALC_OFS_LINK_RATE) begin
      rate_nxt = smb_wdata_i;
    end
    if (smb_wr_i && smb_addr_i == `ALC_OFS_LANE_CNT) begin
      lane_nxt = smb_wdata_i & `ALC_LANE_WR_MASK;
    end
    if (aux_byte_i.valid) begin
      idx_nxt = idx_r + 8'h01;
      if (aux_byte_i.start && !aux_byte_i.from_sink) begin
        st_nxt = alc_pkg::ALC_ST_REQ;
        idx_nxt = 8'h01;
        cmd_nxt = aux_byte_i.data[7:4];
        addr_nxt = {aux_byte_i.data[3:0], 16'h0000};
        pend_rate_k_nxt = 9'h100;
        pend_lane_k_nxt = 9'h100;
      end else if (aux_byte_i.start) begin
        st_nxt = alc_pkg::ALC_ST_REPLY;
        idx_nxt = `ALC_HDR_BYTES;
        if (aux_byte_i.data == `ALC_REPLY_ACK) begin
          ack_nxt = 1'b1;
          if (cmd_r == `ALC_CMD_NATIVE_WR) begin
            if (!pend_rate_k_r[8]) begin
              rate_nxt = pend_rate_r;
            end
            if (!pend_lane_k_r[8]) begin
              lane_nxt = pend_lane_r & `ALC_LANE_WR_MASK;
            end
            // Consume the pending bytes so a stray second reply cannot apply them again.
            pend_rate_k_nxt = 9'h100;
            pend_lane_k_nxt = 9'h100;
          end
        end else if (aux_byte_i.data == `ALC_REPLY_NACK) begin
          nack_nxt = 1'b1;
          st_nxt = alc_pkg::ALC_ST_NACK_CNT;
        end else begin
          st_nxt = alc_pkg::ALC_ST_IDLE;
        end
      end else begin
        case (st_r)
          alc_pkg::ALC_ST_REQ: begin
            if (idx_r == 8'h01) begin
              addr_nxt = {addr_r[19:16], aux_byte_i.data, 8'h00};
            end else if (idx_r == 8'h02) begin
              addr_nxt = {addr_r[19:8], aux_byte_i.data};
            end else if (idx_r >= `ALC_HDR_BYTES && cmd_r == `ALC_CMD_NATIVE_WR) begin
              if (cur_addr == `ALC_AUX_ADDR_LINK_RATE) begin
                pend_rate_nxt = aux_byte_i.data;
                pend_rate_k_nxt = dk;
              end
              if (cur_addr == `ALC_AUX_ADDR_LANE_CNT) begin
                pend_lane_nxt = aux_byte_i.data;
                pend_lane_k_nxt = dk;
              end
            end
          end
          alc_pkg::ALC_ST_REPLY: begin
            // Read data is taken per byte, so an early stop is harmless.
            if (cmd_r == `ALC_CMD_NATIVE_RD) begin
              if (cur_addr == `ALC_AUX_ADDR_LINK_RATE) begin
                rate_nxt = aux_byte_i.data;
              end
              if (cur_addr == `ALC_AUX_ADDR_LANE_CNT) begin
                lane_nxt = aux_byte_i.data & `ALC_LANE_WR_MASK;
              end
            end
          end
          alc_pkg::ALC_ST_NACK_CNT: begin
            // Only the first M payload bytes were accepted; M of zero applies none.
            if (cmd_r == `ALC_CMD_NATIVE_WR) begin
              if (pend_rate_k_r < {1'b0, aux_byte_i.data}) begin
                rate_nxt = pend_rate_r;
              end
              if (pend_lane_k_r < {1'b0, aux_byte_i.data}) begin
                lane_nxt = pend_lane_r & `ALC_LANE_WR_MASK;
              end
            end
            pend_rate_k_nxt = 9'h100;
            pend_lane_k_nxt = 9'h100;
            st_nxt = alc_pkg::ALC_ST_IDLE;
          end
          default: begin
            st_nxt = alc_pkg::ALC_ST_IDLE;
          end
        endcase
      end
      if (aux_byte_i.stop && !aux_byte_i.start && st_nxt != alc_pkg::ALC_ST_REQ) begin
        st_nxt = alc_pkg::ALC_ST_IDLE;
      end
    end
  end

  // ***************************************************************
  // Derived outputs and register readback
  // ***************************************************************
  always_comb begin
    mbps_nxt = 17'(rate_nxt) * `ALC_RATE_STEP_MBPS;
    case (rate_nxt)
      `ALC_RATE_1G62: code_nxt = alc_pkg::ALC_RATE_162;
      `ALC_RATE_2G70: code_nxt = alc_pkg::ALC_RATE_270;
      `ALC_RATE_5G40: code_nxt = alc_pkg::ALC_RATE_540;
      default: code_nxt = alc_pkg::ALC_RATE_RSVD;
    endcase
    case (lane_nxt[`ALC_LANE_CNT_MSB:`ALC_LANE_CNT_LSB])
      `ALC_LANES_ONE: lane_en_nxt = 4'h1;
      `ALC_LANES_TWO: lane_en_nxt = 4'h3;
      `ALC_LANES_FOUR: lane_en_nxt = 4'hF;
      default: lane_en_nxt = 4'h0;
    endcase
    case (smb_addr_i)
      `ALC_OFS_LINK_RATE: rdata_nxt = rate_nxt;
      `ALC_OFS_LANE_CNT: rdata_nxt = lane_nxt;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r <= alc_pkg::ALC_ST_IDLE;
      idx_r <= 8'h00;
      cmd_r <= 4'h0;
      addr_r <= 20'h00000;
      pend_rate_r <= 8'h00;
      pend_lane_r <= 8'h00;
      pend_rate_k_r <= 9'h100;
      pend_lane_k_r <= 9'h100;
      ack_r <= 1'b0;
      nack_r <= 1'b0;
      rate_r <= `ALC_RST_LINK_RATE;
      lane_r <= `ALC_RST_LANE_CNT;
      rdata_r <= 8'h00;
      code_r <= alc_pkg::ALC_RATE_540;
      mbps_r <= `ALC_RST_RATE_MBPS;
      lane_en_r <= 4'hF;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      pend_rate_r <= pend_rate_nxt;
      pend_lane_r <= pend_lane_nxt;
      pend_rate_k_r <= pend_rate_k_nxt;
      pend_lane_k_r <= pend_lane_k_nxt;
      ack_r <= ack_nxt;
      nack_r <= nack_nxt;
      rate_r <= rate_nxt;
      lane_r <= lane_nxt;
      rdata_r <= rdata_nxt;
      code_r <= code_nxt;
      mbps_r <= mbps_nxt;
      lane_en_r <= lane_en_nxt;
    end
  end

  assign smb_rdata_o = rdata_r;
  assign link_rate_o = rate_r;
  assign lane_count_o = lane_r;
  assign rate_code_o = code_r;
  assign rate_mbps_o = mbps_r;
  assign lane_enable_o = lane_en_r;
  assign enhanced_framing_o = lane_r[`ALC_LANE_EF_BIT];
  assign ack_seen_o = ack_r;
  assign nack_seen_o = nack_r;

endmodule // alc_listener

// file: rtl/alc_pkg.sv
// Types shared by the AUX link config listener.
package alc_pkg;

  // Decoded AUX byte as delivered by the AUX receiver front end.
  typedef struct packed {
    logic valid;
    logic from_sink;
    logic start;
    logic stop;
    logic [7:0] data;
  } alc_aux_byte_t;

  typedef enum logic [1:0] {
    ALC_ST_IDLE = 2'b00,
    ALC_ST_REQ = 2'b01,
    ALC_ST_REPLY = 2'b10,
    ALC_ST_NACK_CNT = 2'b11
  } alc_state_t;

  typedef enum logic [1:0] {
    ALC_RATE_RSVD = 2'b00,
    ALC_RATE_162 = 2'b01,
    ALC_RATE_270 = 2'b10,
    ALC_RATE_540 = 2'b11
  } alc_rate_t;

endpackage

// file: test/alc_aux_peer.sv
// Behavioural AUX source and sink pair feeding decoded bytes to the listener.
`timescale 1ns/100ps
`include "alc_consts.svh"
module alc_aux_peer (
  input wire logic core_clk_i,
  output alc_pkg::alc_aux_byte_t aux_o
);
  initial aux_o = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
  task automatic put(input logic snk, input logic st, input logic sp, input logic [7:0] d);
    @(negedge core_clk_i);
    aux_o <= '{1'b1, snk, st, sp, d};
  endtask
  // Between frames the data lane shows the inverse of the last byte, so nothing stale passes.
  task automatic idle();
    @(negedge core_clk_i);
    aux_o <= '{1'b0, 1'b0, 1'b0, 1'b0, ~aux_o.data};
  endtask
  task automatic req(input logic [3:0] cmd, input logic [19:0] adr, input int n,
                     input logic [7:0] d0, input logic [7:0] d1);
    logic wr;
    wr = (cmd == `ALC_CMD_NATIVE_WR);
    put(1'b0, 1'b1, 1'b0, {cmd, adr[19:16]});
    put(1'b0, 1'b0, 1'b0, adr[15:8]);
    put(1'b0, 1'b0, 1'b0, adr[7:0]);
    put(1'b0, 1'b0, !wr, 8'(n - 1));
    if (wr) put(1'b0, 1'b0, n == 1, d0);
    if (wr && n > 1) put(1'b0, 1'b0, 1'b1, d1);
    idle();
  endtask
  // A read reply may stop before the requested count when bytes are unavailable.
  task automatic rpl(input logic [7:0] code, input int n, input logic [7:0] d0,
                     input logic [7:0] d1);
    put(1'b1, 1'b1, n == 0, code);
    if (n > 0) put(1'b1, 1'b0, n == 1, d0);
    if (n > 1) put(1'b1, 1'b0, 1'b1, d1);
    idle();
  endtask
endmodule // alc_aux_peer

// file: test/alc_listener_assertions.sv
// Port-level assertion checker for the AUX link config listener.
`timescale 1ns/100ps
`include "alc_consts.svh"
module alc_listener_assertions (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input alc_pkg::alc_aux_byte_t aux_byte_i,
  input wire logic [7:0] smb_addr_i,
  input wire logic smb_wr_i,
  input wire logic [7:0] smb_wdata_i,
  input wire logic [7:0] smb_rdata_o,
  input wire logic [7:0] link_rate_o,
  input wire logic [7:0] lane_count_o,
  input alc_pkg::alc_rate_t rate_code_o,
  input wire logic [16:0] rate_mbps_o,
  input wire logic [3:0] lane_enable_o,
  input wire logic enhanced_framing_o,
  input wire logic ack_seen_o,
  input wire logic nack_seen_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence reply_code_s(logic [7:0] code);
    aux_byte_i.valid && aux_byte_i.from_sink && aux_byte_i.start && aux_byte_i.data == code;
  endsequence
  ack_pulse_a: assert property (reply_code_s(`ALC_REPLY_ACK) |=> ack_seen_o)
    else $error("acknowledge reply not flagged");
  nack_pulse_a: assert property (reply_code_s(`ALC_REPLY_NACK) |=> nack_seen_o)
    else $error("refusal reply not flagged");
  rate_code_a: assert property (rate_code_o == (link_rate_o == 8'h06 ? alc_pkg::ALC_RATE_162 :
    link_rate_o == 8'h0A ? alc_pkg::ALC_RATE_270 : link_rate_o == 8'h14 ?
    alc_pkg::ALC_RATE_540 : alc_pkg::ALC_RATE_RSVD)) else $error("rate code wrong");
  rate_mbps_a: assert property (rate_mbps_o == 17'(link_rate_o) * 17'h0010E)
    else $error("rate in Mbps wrong");
  lane_map_a: assert property (lane_enable_o == (lane_count_o[4:0] == 5'h01 ? 4'h1 :
    lane_count_o[4:0] == 5'h02 ? 4'h3 : lane_count_o[4:0] == 5'h04 ? 4'hF : 4'h0))
    else $error("lane enables wrong");
  lane_rsvd_a: assert property (lane_count_o[6:5] == 2'h0)
    else $error("reserved lane bits set");
  frame_en_a: assert property (enhanced_framing_o == lane_count_o[7])
    else $error("enhanced framing wrong");
  smb_lane_a: assert property (smb_wr_i && smb_addr_i == 8'h03 && !aux_byte_i.valid
    |=> lane_count_o == ($past(smb_wdata_i) & 8'h9F)) else $error("lane write lost");
  smb_read_a: assert property (!$past(reset_i) && $past(smb_addr_i) == 8'h03
    |-> smb_rdata_o == lane_count_o) else $error("register read wrong");
  lane_hold_a: assert property (!$past(reset_i) && !$past(smb_wr_i) && !$past(aux_byte_i.valid)
    |-> $stable(lane_count_o)) else $error("lane count changed without cause");
endmodule // alc_listener_assertions
bind alc_listener alc_listener_assertions alc_listener_assertions_i (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .aux_byte_i(aux_byte_i),
  .smb_addr_i(smb_addr_i), .smb_wr_i(smb_wr_i), .smb_wdata_i(smb_wdata_i),
  .smb_rdata_o(smb_rdata_o), .link_rate_o(link_rate_o), .lane_count_o(lane_count_o),
  .rate_code_o(rate_code_o), .rate_mbps_o(rate_mbps_o), .lane_enable_o(lane_enable_o),
  .enhanced_framing_o(enhanced_framing_o), .ack_seen_o(ack_seen_o),
  .nack_seen_o(nack_seen_o));

// file: test/aux_link_config_listener_tb_top.sv
// Self-checking testbench for the AUX link config listener.
`timescale 1ns/100ps
`include "alc_consts.svh"
module aux_link_config_listener_tb_top;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  alc_pkg::alc_aux_byte_t aux_byte;
  logic [7:0] smb_addr = 8'h00;
  logic smb_wr = 1'b0;
  logic [7:0] smb_wdata = 8'h00;
  logic [7:0] smb_rdata, link_rate, lane_count;
  alc_pkg::alc_rate_t rate_code;
  logic [16:0] rate_mbps;
  logic [3:0] lane_en;
  logic ef, ack, nack;
  int err_count = 0;
  int samples_checked = 0;
  always #50 core_clk_i = ~core_clk_i;
  alc_aux_peer alc_aux_peer_i (.core_clk_i(core_clk_i), .aux_o(aux_byte));
  alc_listener alc_listener_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .aux_byte_i(aux_byte), .smb_addr_i(smb_addr), .smb_wr_i(smb_wr), .smb_wdata_i(smb_wdata),
    .smb_rdata_o(smb_rdata), .link_rate_o(link_rate), .lane_count_o(lane_count),
    .rate_code_o(rate_code), .rate_mbps_o(rate_mbps), .lane_enable_o(lane_en),
    .enhanced_framing_o(ef), .ack_seen_o(ack), .nack_seen_o(nack));
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic smb_w(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    smb_addr = a;
    smb_wdata = d;
    smb_wr = 1'b1;
    @(negedge core_clk_i);
    smb_wr = 1'b0;
  endtask
  task automatic smb_r(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk_i);
    smb_addr = a;
    @(negedge core_clk_i);
    chk("smb_rdata", 17'(exp), 17'(smb_rdata));
  endtask
  task automatic t_reset();
    chk("lane_count", 17'h00004, 17'(lane_count));
    chk("rate_mbps", 17'h01518, rate_mbps);
    chk("lane_en", 17'h0000F, 17'(lane_en));
    smb_r(8'h02, 8'h14);
  endtask
  task automatic t_rates();
    logic [7:0] codes [3] = '{8'h06, 8'h0A, 8'h14};
    for (int i = 0; i < 3; i++) begin
      smb_w(8'h02, codes[i]);
      chk("rate_code", 17'(i + 1), 17'(rate_code));
      chk("rate_mbps", 17'(codes[i]) * 17'h0010E, rate_mbps);
    end
    smb_w(8'h02, 8'h07);
    chk("rate_code", 17'h00000, 17'(rate_code));
  endtask
  task automatic t_lanes();
    logic [4:0] cnt [3] = '{5'h01, 5'h02, 5'h04};
    logic [3:0] en [3] = '{4'h1, 4'h3, 4'hF};
    for (int i = 0; i < 3; i++) begin
      smb_w(8'h03, {3'h0, cnt[i]});
      chk("lane_en", 17'(en[i]), 17'(lane_en));
    end
    smb_w(8'h03, 8'hFF);
    chk("lane_en", 17'h00000, 17'(lane_en));
    smb_r(8'h03, 8'h9F);
    chk("frame_en", 17'h00001, 17'(ef));
    smb_r(8'h05, 8'h00);
  endtask
  // The write stays pending until the sink answers, so the mirror must not move early.
  task automatic t_aux_ack();
    smb_w(8'h03, 8'h01);
    alc_aux_peer_i.req(`ALC_CMD_NATIVE_WR, `ALC_AUX_ADDR_LANE_CNT, 1, 8'h82, 8'h00);
    chk("lane_count", 17'h00001, 17'(lane_count));
    alc_aux_peer_i.rpl(`ALC_REPLY_ACK, 0, 8'h00, 8'h00);
    chk("ack", 17'h00001, 17'(ack));
    chk("lane_count", 17'h00082, 17'(lane_count));
    chk("lane_en", 17'h00003, 17'(lane_en));
  endtask
  task automatic t_aux_nack();
    alc_aux_peer_i.req(`ALC_CMD_NATIVE_WR, `ALC_AUX_ADDR_LINK_RATE, 2, 8'h06, 8'h04);
    // The refusal flag stands only while the count byte is on the link, so look then.
    fork
      alc_aux_peer_i.rpl(`ALC_REPLY_NACK, 1, 8'h01, 8'h00);
      begin
        repeat (2) @(negedge core_clk_i);
        chk("nack", 17'h00001, 17'(nack));
      end
    join
    chk("link_rate", 17'h00006, 17'(link_rate));
    chk("lane_count", 17'h00082, 17'(lane_count));
    alc_aux_peer_i.req(`ALC_CMD_NATIVE_WR, `ALC_AUX_ADDR_LINK_RATE, 1, 8'h0A, 8'h00);
    alc_aux_peer_i.rpl(`ALC_REPLY_NACK, 1, 8'h00, 8'h00);
    chk("link_rate", 17'h00006, 17'(link_rate));
  endtask
  task automatic t_aux_rd();
    alc_aux_peer_i.req(`ALC_CMD_NATIVE_RD, `ALC_AUX_ADDR_LINK_RATE, 2, 8'h00, 8'h00);
    alc_aux_peer_i.rpl(`ALC_REPLY_ACK, 1, 8'h14, 8'h00);
    chk("link_rate", 17'h00014, 17'(link_rate));
    chk("lane_count", 17'h00082, 17'(lane_count));
  endtask
  task automatic t_mid_reset();
    @(negedge core_clk_i);
    reset_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    reset_i = 1'b0;
    chk("lane_count", 17'h00004, 17'(lane_count));
    chk("frame_en", 17'h00000, 17'(ef));
    chk("rate_code", 17'h00003, 17'(rate_code));
    chk("rate_mbps", 17'h01518, rate_mbps);
    chk("smb_rdata", 17'h00000, 17'(smb_rdata));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge core_clk_i);
    reset_i = 1'b0;
    t_reset();
    t_rates();
    t_lanes();
    t_aux_ack();
    t_aux_nack();
    t_aux_rd();
    t_mid_reset();
    report_and_stop();
  end
  initial begin
    #(100 * 2000);
    err_count++;
    report_and_stop();
  end
endmodule // aux_link_config_listener_tb_top
